/* common/cbr_map.svh */
`ifndef CBR_MAP_SVH
`define CBR_MAP_SVH
// Register byte offsets
`define CBR_CTRL_OFS   8'h00
`define CBR_INFO_OFS   8'h04
`define CBR_ERC_OFS    8'h08
`define CBR_BRP_OFS    8'h0c
`define CBR_BTR_OFS    8'h10
// Operating mode codes
`define CBR_MODE_INIT  3'h0
`define CBR_MODE_NORM  3'h1
`define CBR_MODE_SLEEP 3'h5
`define CBR_MODE_STOP  3'h6
// Control register fields
`define CBR_CCE_BIT    3
`define CBR_GOE_BIT    4
`define CBR_PEND_BIT   5
// Information register fields
`define CBR_BUS_OFF_FLAG_BIT   4
`define CBR_EPAS_BIT   3
// Counter limits
`define CBR_RUN_BITS   4'hb
`define CBR_REC_LAST   8'h7f
`define CBR_PASS_LIM   8'h80
`define CBR_TEC_BUS_OFF_FLAG   8'hf8
`define CBR_ERR_STEP   8'h08
// Bit timing reset values
`define CBR_BRP_RST    8'h00
`define CBR_TIME_SEGMENT_ONE_RST  4'h7
`define CBR_TIME_SEGMENT_TWO_RST  3'h6
`endif

/* common/cbr_pkg.sv */
package cbr_pkg;
  typedef enum logic [3:0] {
    ST_INIT  = 4'b0001,
    ST_OPER  = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_STOP  = 4'b1000
  } cbr_state_e;
  typedef logic [7:0] cbr_cnt_t;
endpackage : cbr_pkg

/* rtl/cbr_bit_timing.sv */
`timescale 1ns/1ps
`include "cbr_map.svh"
module cbr_bit_timing import cbr_pkg::*; (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] brp,
  input  wire logic [3:0] time_segment_one,
  input  wire logic [2:0] time_segment_two,
  input  wire logic       rx_bit,
  input  wire logic       hsync_edge,
  output logic            tq_en,
  output logic            sample_pulse,
  output logic            sample_bit
);
  logic [7:0] pre_r;
  logic [4:0] pos_r;
  logic [4:0] seg1_end;
  logic [4:0] bit_end;

  // Segment boundaries in quanta: sync is position 0
  assign seg1_end = {1'b0, time_segment_one} + 5'h01;
  assign bit_end  = seg1_end + {2'b00, time_segment_two} + 5'h01;
  assign tq_en    = (pre_r == brp);
  assign sample_pulse = tq_en && (pos_r == seg1_end);

  // Prescaler divides by brp+1, so 1 to 256
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_r <= 8'h00;
    end else if (hsync_edge || tq_en) begin
      pre_r <= 8'h00;
    end else begin
      pre_r <= pre_r + 8'h01;
    end
  end

  // Quantum position inside the bit; an edge ends the sync quantum, so position 1 follows
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_r <= 5'h00;
    end else if (hsync_edge) begin
      pos_r <= 5'h01;
    end else if (tq_en) begin
      // A shorter bit set mid-bit ends at once rather than wrapping
      pos_r <= (pos_r >= bit_end) ? 5'h00 : pos_r + 5'h01;
    end
  end

  // Sampled level held for the sample_bit output
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_bit <= 1'b1;
    end else if (sample_pulse) begin
      sample_bit <= rx_bit;
    end
  end
endmodule : cbr_bit_timing

/* rtl/cbr_ctrl.sv */
`timescale 1ns/1ps
`include "cbr_map.svh"
module cbr_ctrl import cbr_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        can_rx_in,
  input  wire logic        proto_tx_bit,
  input  wire logic        bus_idle,
  input  wire logic        err_event,
  input  wire logic        err_tx_node,
  input  wire logic        err_intermission,
  input  wire logic        err_flag_done,
  input  wire logic        tx_ok,
  input  wire logic        rx_ok,
  output logic             can_tx_out,
  output logic             err_flag_req,
  output logic             err_flag_passive,
  output logic             ovld_req,
  output logic             sample_pulse,
  output logic             sample_bit
);
  cbr_state_e state_r;
  logic [2:0] mode_r;
  logic [2:0] pend_r;
  logic       recov_r;
  logic       bus_off_flag_r;
  logic       joined_r;
  logic       goe_r;
  cbr_cnt_t   tec_r;
  cbr_cnt_t   rec_r;
  logic       err_pend_r;
  logic       err_tx_r;
  logic [7:0] brp_r;
  logic [3:0] time_segment_one_r;
  logic [2:0] time_segment_two_r;
  logic [1:0] sjw_r;
  logic       rx_s1_r;
  logic       rx_s2_r;
  logic       rx_s3_r;
  logic       tx_r;
  logic       ack_r;
  logic [31:0] dat_r;
  logic       wr_stb;
  logic       wr_ctrl;
  logic [2:0] req;
  logic       cce_w;
  logic       run_pulse;
  logic       fall_edge;
  logic       tq_en;
  logic       rec_start;
  logic       forced;
  logic       rec_done;
  logic       wake;
  logic       cce_init;
  logic       count_ok;
  logic [2:0] operating_mode_field_rd;

  // True for any mode code that is an operation mode
  function automatic logic is_oper(input logic [2:0] m);
    is_oper = (m != `CBR_MODE_INIT) && (m != `CBR_MODE_SLEEP) &&
              (m != `CBR_MODE_STOP);
  endfunction : is_oper

  // Bus strobes; a write lands on the edge where the master sees ack
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign wr_stb   = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  assign wr_ctrl  = wr_stb && (wb_adr_i == `CBR_CTRL_OFS) && wb_sel_i[0];
  assign req      = wb_dat_i[2:0];
  assign cce_w    = wb_dat_i[`CBR_CCE_BIT];

  // Recovery events
  assign fall_edge = rx_s3_r && !rx_s2_r;
  assign wake      = (state_r == ST_SLEEP) && bus_off_flag_r && fall_edge;
  assign forced    = (state_r == ST_INIT) && bus_off_flag_r && wr_ctrl &&
                     is_oper(req) && cce_w;
  assign rec_start = bus_off_flag_r && !forced &&
                     (((state_r == ST_INIT) && wr_ctrl && is_oper(req)) ||
                      ((state_r == ST_SLEEP) && wr_ctrl && is_oper(req)) ||
                      wake);
  assign rec_done  = recov_r && run_pulse && (rec_r == `CBR_REC_LAST);
  assign cce_init  = (state_r == ST_INIT) && wr_ctrl && cce_w &&
                     !recov_r && !rec_start;
  assign count_ok  = (state_r == ST_OPER) && !bus_off_flag_r;

  // Mode field reads the mode entered, never the pending request
  always_comb begin
    case (state_r)
      ST_OPER:  operating_mode_field_rd = mode_r;
      ST_SLEEP: operating_mode_field_rd = `CBR_MODE_SLEEP;
      ST_STOP:  operating_mode_field_rd = `CBR_MODE_STOP;
      default:  operating_mode_field_rd = `CBR_MODE_INIT;
    endcase
  end

  // Two-stage pin synchroniser plus one stage for edge detection
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
    end else begin
      rx_s1_r <= can_rx_in;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
    end
  end

  // Mode state machine
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_INIT;
      mode_r  <= `CBR_MODE_INIT;
    end else begin
      case (state_r)
        ST_INIT: begin
          if (rec_done) begin
            state_r <= ST_OPER;
            mode_r  <= pend_r;
          end else if (wr_ctrl && is_oper(req) && (!bus_off_flag_r || cce_w)) begin
            state_r <= ST_OPER;
            mode_r  <= req;
          end else if (wr_ctrl && req == `CBR_MODE_SLEEP) begin
            state_r <= ST_SLEEP;
          end else if (wr_ctrl && req == `CBR_MODE_STOP) begin
            state_r <= ST_STOP;
          end
        end
        ST_OPER: begin
          if (wr_ctrl && req == `CBR_MODE_INIT) begin
            state_r <= ST_INIT;
          end else if (wr_ctrl && req == `CBR_MODE_SLEEP) begin
            state_r <= ST_SLEEP;
          end else if (wr_ctrl && req == `CBR_MODE_STOP) begin
            state_r <= ST_STOP;
          end else if (wr_ctrl && is_oper(req)) begin
            mode_r <= req;
          end
        end
        ST_SLEEP: begin
          if (rec_start) begin
            state_r <= ST_INIT;
          end else if (wr_ctrl && is_oper(req)) begin
            state_r <= ST_OPER;
            mode_r  <= req;
          end else if (fall_edge) begin
            state_r <= ST_OPER;
          end else if (wr_ctrl && req == `CBR_MODE_STOP) begin
            state_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (wr_ctrl && req == `CBR_MODE_SLEEP) begin
            state_r <= ST_SLEEP;
          end
        end
        default: begin
          state_r <= ST_INIT;
        end
      endcase
    end
  end

  // Pending request and recovery flag
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      recov_r <= 1'b0;
      pend_r  <= `CBR_MODE_NORM;
    end else if (rec_start) begin
      recov_r <= 1'b1;
      pend_r  <= wake ? (is_oper(mode_r) ? mode_r : `CBR_MODE_NORM) : req;
    end else if (rec_done || forced) begin
      recov_r <= 1'b0;
    end
  end

  // Bus-off flag and join gate
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_off_flag_r   <= 1'b0;
      joined_r <= 1'b1;
    end else begin
      if (count_ok && err_flag_done && err_pend_r && err_tx_r &&
          tec_r >= `CBR_TEC_BUS_OFF_FLAG) begin
        bus_off_flag_r <= 1'b1;
      end else if (rec_done || forced || cce_init) begin
        bus_off_flag_r <= 1'b0;
      end
      if (forced) begin
        joined_r <= 1'b0;
      end else if (run_pulse) begin
        joined_r <= 1'b1;
      end
    end
  end

  // Error counters; the recovery path takes priority over errors
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tec_r <= 8'h00;
      rec_r <= 8'h00;
    end else if (rec_start || rec_done || forced || cce_init) begin
      tec_r <= 8'h00;
      rec_r <= 8'h00;
    end else if (recov_r) begin
      if (run_pulse) begin
        rec_r <= rec_r + 8'h01;
      end
    end else if (count_ok) begin
      if (err_flag_done && err_pend_r) begin
        if (err_tx_r && tec_r < `CBR_TEC_BUS_OFF_FLAG) begin
          tec_r <= tec_r + `CBR_ERR_STEP;
        end else if (!err_tx_r && rec_r != 8'hff) begin
          rec_r <= rec_r + 8'h01;
        end
      end else if (tx_ok && tec_r != 8'h00) begin
        tec_r <= tec_r - 8'h01;
      end else if (rx_ok && rec_r != 8'h00) begin
        rec_r <= rec_r - 8'h01;
      end
    end
  end

  // Flag requests; the flag kind is frozen before the counts move
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      err_pend_r       <= 1'b0;
      err_tx_r         <= 1'b0;
      err_flag_req     <= 1'b0;
      err_flag_passive <= 1'b0;
      ovld_req         <= 1'b0;
    end else begin
      err_flag_req <= 1'b0;
      ovld_req     <= 1'b0;
      if (count_ok && err_event && err_intermission) begin
        ovld_req <= 1'b1;
      end else if (count_ok && err_event) begin
        err_flag_req     <= 1'b1;
        err_pend_r       <= 1'b1;
        err_tx_r         <= err_tx_node;
        err_flag_passive <= (tec_r >= `CBR_PASS_LIM) ||
                            (rec_r >= `CBR_PASS_LIM);
      end else if (err_flag_done) begin
        err_pend_r <= 1'b0;
      end
      // Clearing in init also returns the flag kind to its default
      if (cce_init) begin
        err_flag_passive <= 1'b0;
      end
    end
  end

  // Transmit pin is registered; recessive unless fully on the bus
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_r <= 1'b1;
    end else begin
      tx_r <= (bus_off_flag_r || !joined_r || state_r != ST_OPER || !goe_r) ?
              1'b1 : proto_tx_bit;
    end
  end
  assign can_tx_out = tx_r;

  // Writable configuration; timing only changes in init
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      goe_r   <= 1'b0;
      brp_r   <= `CBR_BRP_RST;
      time_segment_one_r <= `CBR_TIME_SEGMENT_ONE_RST;
      time_segment_two_r <= `CBR_TIME_SEGMENT_TWO_RST;
      sjw_r   <= 2'h0;
    end else if (wr_stb) begin
      if (wb_adr_i == `CBR_CTRL_OFS && wb_sel_i[0]) begin
        goe_r <= wb_dat_i[`CBR_GOE_BIT];
      end
      if (wb_adr_i == `CBR_BRP_OFS && wb_sel_i[0] &&
          state_r == ST_INIT) begin
        brp_r <= wb_dat_i[7:0];
      end
      if (wb_adr_i == `CBR_BTR_OFS && state_r == ST_INIT) begin
        if (wb_sel_i[0]) begin
          time_segment_one_r <= (wb_dat_i[3:0] == 4'h0) ? 4'h1 : wb_dat_i[3:0];
        end
        if (wb_sel_i[1]) begin
          time_segment_two_r <= wb_dat_i[10:8];
          sjw_r   <= wb_dat_i[13:12];
        end
      end
    end
  end

  // Slave answers one cycle after the request; unmapped reads give 0
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      case (wb_adr_i)
        `CBR_CTRL_OFS: dat_r <= {26'h0, recov_r, goe_r, 1'b0, operating_mode_field_rd};
        `CBR_INFO_OFS: dat_r <= {27'h0, bus_off_flag_r, err_flag_passive, 3'h0};
        `CBR_ERC_OFS:  dat_r <= {16'h0, rec_r, bus_off_flag_r ? 8'h00 : tec_r};
        `CBR_BRP_OFS:  dat_r <= {24'h0, brp_r};
        `CBR_BTR_OFS:  dat_r <= {18'h0, sjw_r, 1'b0, time_segment_two_r, 4'h0, time_segment_one_r};
        default:       dat_r <= 32'h0000_0000;
      endcase
    end
  end

  cbr_bit_timing u_timing (
    .ref_clk      (ref_clk),
    .reset_n      (reset_n),
    .brp          (brp_r),
    .time_segment_one        (time_segment_one_r),
    .time_segment_two        (time_segment_two_r),
    .rx_bit       (rx_s2_r),
    .hsync_edge   (fall_edge && bus_idle),
    .tq_en        (tq_en),
    .sample_pulse (sample_pulse),
    .sample_bit   (sample_bit)
  );

  // Runs count only while recovering or waiting to join
  cbr_run_det u_run (
    .ref_clk      (ref_clk),
    .reset_n      (reset_n),
    .enable       (recov_r || !joined_r),
    .sample_pulse (sample_pulse),
    .rx_bit       (rx_s2_r),
    .run_pulse    (run_pulse)
  );

  a_tx_bus_off_flag_rec: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(bus_off_flag_r) |-> can_tx_out) else $error("tx not recessive");
  a_init_grant: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_OPER && wr_ctrl && req == `CBR_MODE_INIT) |=>
    (state_r == ST_INIT && operating_mode_field_rd == 3'h0)) else $error("init");
  a_pend_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (recov_r && !rec_done && !forced && state_r == ST_INIT &&
     !(wr_ctrl && (req == `CBR_MODE_SLEEP || req == `CBR_MODE_STOP)))
    |=> state_r == ST_INIT) else $error("left init early");
  a_bus_off_flag_recov: assert property (@(posedge ref_clk) disable iff (!reset_n)
    recov_r |-> bus_off_flag_r) else $error("flag dropped");
  a_rec_step: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (recov_r && run_pulse && !rec_done && !rec_start && !forced) |=>
    rec_r == $past(rec_r) + 8'h01) else $error("rec step");
  a_restart_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rec_start |=> (rec_r == 8'h00 && recov_r)) else $error("restart");
  a_sleep_refuse: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_SLEEP && wr_ctrl && req == `CBR_MODE_INIT && !fall_edge)
    |=> state_r == ST_SLEEP) else $error("init in sleep");
  a_forced_enter: assert property (@(posedge ref_clk) disable iff (!reset_n)
    forced |=> (state_r == ST_OPER && !bus_off_flag_r && !joined_r))
    else $error("forced");
  a_ovld_req: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (count_ok && err_event && err_intermission) |=>
    (ovld_req && !err_flag_req)) else $error("overload");
  c_forced: cover property (@(posedge ref_clk) disable iff (!reset_n)
    forced ##[1:1000] joined_r);
  c_recovered: cover property (@(posedge ref_clk) disable iff (!reset_n)
    rec_done);
  c_wake: cover property (@(posedge ref_clk) disable iff (!reset_n) wake);
endmodule : cbr_ctrl

/* rtl/cbr_run_det.sv */
`timescale 1ns/1ps
`include "cbr_map.svh"
module cbr_run_det import cbr_pkg::*; (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic enable,
  input  wire logic sample_pulse,
  input  wire logic rx_bit,
  output logic      run_pulse
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  // A dominant sample restarts the count of recessive bits
  always_comb begin
    cnt_nxt = rx_bit ? cnt_r + 4'h1 : 4'h0;
  end

  // Pulse on every eleventh recessive sample, then count again
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r     <= 4'h0;
      run_pulse <= 1'b0;
    end else begin
      run_pulse <= 1'b0;
      if (!enable) begin
        cnt_r <= 4'h0;
      end else if (sample_pulse) begin
        if (cnt_nxt == `CBR_RUN_BITS) begin
          cnt_r     <= 4'h0;
          run_pulse <= 1'b1;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
    end
  end
endmodule : cbr_run_det

/* verif/can_busoff_recovery_bit_timing_tb_top.sv */
`timescale 1ns/1ps
`include "cbr_map.svh"
module can_busoff_recovery_bit_timing_tb_top import cbr_pkg::*;;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, seed = 32'hc7f3;
  logic        ack, can_rx, can_tx, fl_req, fl_pas, ov_req, spl, sbit;
  logic        ptx = 1'b1, ev = 1'b0, im_r = 1'b0, done = 1'b0, dom = 1'b0;
  int          miscompares = 0, tests_run = 0, tx_error_count = 0;

  // Clock at 25 MHz
  always #20 ref_clk = ~ref_clk;

  cbr_ctrl dut (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .can_rx_in(can_rx),
    .proto_tx_bit(ptx), .bus_idle(1'b1), .err_event(ev),
    .err_tx_node(1'b1), .err_intermission(im_r), .err_flag_done(done),
    .tx_ok(1'b0), .rx_ok(1'b0), .can_tx_out(can_tx), .err_flag_req(fl_req),
    .err_flag_passive(fl_pas), .ovld_req(ov_req), .sample_pulse(spl),
    .sample_bit(sbit));

  cbr_bus_node node (.ref_clk(ref_clk), .tx_bit(can_tx), .dom_req(dom),
    .bus_level(can_rx));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  // One classic cycle; request held until ack is sampled
  task automatic acc(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    {cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, 4'hf, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
    if (n >= 40) miscompares++;
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    acc(a, 1'b0, 32'h0, q);
  endtask : rd

  task automatic wpulse(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (spl !== 1'b1 && n < 5000);
  endtask : wpulse

  // Bit period in clocks follows prescaler and both segments
  task automatic bt(input logic [7:0] b, input logic [3:0] t1,
                    input logic [2:0] t2);
    int n;
    wr(`CBR_BRP_OFS, {24'h0, b});
    wr(`CBR_BTR_OFS, {21'h0, t2, 4'h0, t1});
    repeat (3) wpulse(n);
    chk(n, (b + 1) * (t1 + t2 + 3));
    chk(sbit, 1'b1);
  endtask : bt

  // Error in operation: flag kind uses counts from before the error
  task automatic err(input logic im, input logic pas);
    @(posedge ref_clk);
    {ev, im_r} <= {1'b1, im};
    @(posedge ref_clk);
    ev <= 1'b0;
    @(posedge ref_clk);
    if (im) chk({ov_req, fl_req}, 2'b10);
    else begin
      chk({fl_req, fl_pas}, {1'b1, pas});
      done <= 1'b1;
      @(posedge ref_clk);
      done <= 1'b0;
    end
  endtask : err

  // Drive the transmit count over its ceiling, then probe the pin
  task automatic busoff;
    logic [31:0] q;
    tx_error_count = 0;
    for (int i = 0; i < 32; i++) begin
      err(1'b0, tx_error_count >= 128);
      if (tx_error_count < 248) tx_error_count += 8;
    end
    rd(`CBR_INFO_OFS, q);
    chk(q[`CBR_BUS_OFF_FLAG_BIT], 1'b1);
    rd(`CBR_ERC_OFS, q);
    chk(q[7:0], 8'h00);
    repeat (40) begin
      @(posedge ref_clk);
      ptx <= seed[0];
      seed = nxt(seed);
      chk(can_tx, 1'b1);
    end
    ptx <= 1'b1;
  endtask : busoff

  // Poll until normal mode; in recovery the flag and run count are watched
  task automatic wmode(input logic rec);
    logic [31:0] q, qi, qe;
    logic [7:0]  prv;
    prv = 8'h00;
    qi = 32'h0;
    qe = 32'h0;
    for (int i = 0; i < 3000; i++) begin
      // Status first, mode last: a finish in between voids the status
      if (rec) begin
        rd(`CBR_INFO_OFS, qi);
        rd(`CBR_ERC_OFS, qe);
      end
      rd(`CBR_CTRL_OFS, q);
      if (q[2:0] === `CBR_MODE_NORM) break;
      if (rec) begin
        chk(qi[`CBR_BUS_OFF_FLAG_BIT], 1'b1);
        chk(qe[15:8] >= prv && !qe[15], 1'b1);
        prv = qe[15:8];
      end
    end
    chk(q[2:0], `CBR_MODE_NORM);
    if (rec) chk(prv, `CBR_REC_LAST);
  endtask : wmode

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    logic [31:0] q;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`CBR_CTRL_OFS, q);
    chk(q[5:0], 6'h00);
    rd(`CBR_BTR_OFS, q);
    chk(q, 32'h607);
    rd(8'h20, q);
    chk(q, 32'h0);
    bt(8'hff, 4'h4, 3'h1);
    bt(8'h00, 4'hf, 3'h7);
    for (int i = 0; i < 3; i++) begin
      seed = nxt(seed);
      bt(seed[1:0], 4'h7 + seed[10:8], seed[14:12] % 3'h7);
    end
    bt(8'h00, 4'h4, 3'h1);
    wr(`CBR_CTRL_OFS, 32'h11);
    wmode(1'b0);
    err(1'b1, 1'b0);
    err(1'b0, 1'b0);
    rd(`CBR_ERC_OFS, q);
    chk(q[7:0], 8'h08);
    wr(`CBR_CTRL_OFS, 32'h19);
    rd(`CBR_ERC_OFS, q);
    chk(q[7:0], 8'h08);
    wr(`CBR_CTRL_OFS, 32'h10);
    wr(`CBR_CTRL_OFS, 32'h18);
    rd(`CBR_ERC_OFS, q);
    chk(q, 32'h0);
    rd(`CBR_CTRL_OFS, q);
    chk(q[3:0], 4'h0);
    wr(`CBR_CTRL_OFS, 32'h11);
    wmode(1'b0);
    // Normal recovery, restarted part way
    busoff;
    wr(`CBR_CTRL_OFS, 32'h10);
    rd(`CBR_CTRL_OFS, q);
    chk(q[2:0], `CBR_MODE_INIT);
    wr(`CBR_CTRL_OFS, 32'h11);
    rd(`CBR_CTRL_OFS, q);
    chk({q[5], q[2:0]}, 4'h8);
    repeat (400) @(posedge ref_clk);
    rd(`CBR_ERC_OFS, q);
    chk(q[15:8] != 8'h00, 1'b1);
    wr(`CBR_CTRL_OFS, 32'h11);
    rd(`CBR_ERC_OFS, q);
    chk(q[15:8] < 8'h02, 1'b1);
    wmode(1'b1);
    // Forced recovery
    busoff;
    wr(`CBR_CTRL_OFS, 32'h10);
    wr(`CBR_CTRL_OFS, 32'h19);
    rd(`CBR_CTRL_OFS, q);
    chk(q[3:0], 4'h1);
    rd(`CBR_INFO_OFS, q);
    chk(q[`CBR_BUS_OFF_FLAG_BIT], 1'b0);
    chk(q[`CBR_EPAS_BIT], 1'b0);
    // Pin stays recessive until one recessive run is seen
    ptx <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(can_tx, 1'b1);
    repeat (120) @(posedge ref_clk);
    chk(can_tx, 1'b0);
    ptx <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // Sleep while bus-off, woken by a dominant edge
    busoff;
    wr(`CBR_CTRL_OFS, 32'h15);
    rd(`CBR_CTRL_OFS, q);
    chk(q[2:0], `CBR_MODE_SLEEP);
    wr(`CBR_CTRL_OFS, 32'h10);
    rd(`CBR_CTRL_OFS, q);
    chk(q[2:0], `CBR_MODE_SLEEP);
    dom <= 1'b1;
    repeat (16) @(posedge ref_clk);
    dom <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rd(`CBR_CTRL_OFS, q);
    chk({q[5], q[2:0]}, 4'h8);
    wmode(1'b1);
    // Stop while bus-off; leaving sleep starts recovery, then forced out
    busoff;
    wr(`CBR_CTRL_OFS, 32'h15);
    wr(`CBR_CTRL_OFS, 32'h16);
    wr(`CBR_CTRL_OFS, 32'h10);
    rd(`CBR_CTRL_OFS, q);
    chk(q[2:0], `CBR_MODE_STOP);
    wr(`CBR_CTRL_OFS, 32'h15);
    wr(`CBR_CTRL_OFS, 32'h11);
    rd(`CBR_CTRL_OFS, q);
    chk({q[5], q[2:0]}, 4'h8);
    wr(`CBR_CTRL_OFS, 32'h19);
    rd(`CBR_CTRL_OFS, q);
    chk({q[5], q[3:0]}, 5'h01);
    wrap_up;
  end

  // Watchdog well beyond the expected run of about 30000 cycles
  initial begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    wrap_up;
  end
endmodule : can_busoff_recovery_bit_timing_tb_top

/* verif/cbr_bus_node.sv */
`timescale 1ns/1ps
// Other nodes behind the transceiver: wired-AND bus with loop delay
module cbr_bus_node (
  input  wire logic ref_clk,
  input  wire logic tx_bit,
  input  wire logic dom_req,
  output logic      bus_level
);
  logic [1:0] dly_r = 2'b11;

  // Dominant wins; two stages so the block never sees its own bit at once
  always_ff @(posedge ref_clk) begin
    dly_r <= {dly_r[0], tx_bit & ~dom_req};
  end
  assign bus_level = dly_r[1];
endmodule : cbr_bus_node
